// >>> src/t16b_pkg.sv
package t16b_pkg;
	// ------------------------------------------------------------
	// Byte locations on the I/O bus
	// ------------------------------------------------------------
	localparam logic [3:0] LOC_CTRL_A  = 4'h0;
	localparam logic [3:0] LOC_CTRL_B  = 4'h1;
	localparam logic [3:0] LOC_CNT_LO  = 4'h2;
	localparam logic [3:0] LOC_CNT_HI  = 4'h3;
	localparam logic [3:0] LOC_CMPA_LO = 4'h4;
	localparam logic [3:0] LOC_CMPA_HI = 4'h5;
	localparam logic [3:0] LOC_CMPB_LO = 4'h6;
	localparam logic [3:0] LOC_CMPB_HI = 4'h7;
	localparam logic [3:0] LOC_CAP_LO  = 4'h8;
	localparam logic [3:0] LOC_CAP_HI  = 4'h9;
	localparam logic [3:0] LOC_FLAGS   = 4'hA;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int         CS_LSB      = 0;  // control_reg_b [2:0]
	localparam int         WGM_LO_LSB  = 0;  // control_reg_a [1:0]
	localparam int         WGM_HI_LSB  = 3;  // control_reg_b [4:3]
	localparam int         OVF_BIT     = 0;  // flags register
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam logic [15:0] VAL_RST    = 16'h0000;
	localparam logic [15:0] TOP_8BIT   = 16'h00FF;
	localparam logic [15:0] TOP_9BIT   = 16'h01FF;
	localparam logic [15:0] TOP_10BIT  = 16'h03FF;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;

	// ------------------------------------------------------------
	// Clock source select codes
	// ------------------------------------------------------------
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// ------------------------------------------------------------
	// Host Wishbone map and command fields
	// ------------------------------------------------------------
	localparam logic [3:0] WB_CMD      = 4'h0;
	localparam logic [3:0] WB_STATUS   = 4'h4;
	localparam int         CMD_WR_BIT  = 4;
	localparam int         CMD_WD_BIT  = 5;
	localparam int         CMD_DAT_LSB = 8;

	// Counting behaviour of a waveform mode
	typedef enum logic [1:0] {
		T16B_SEQ_WRAP = 2'b00,  // count up, wrap at MAX
		T16B_SEQ_CTC  = 2'b01,  // clear at top, overflow at MAX
		T16B_SEQ_FAST = 2'b10,  // clear at top, overflow at top
		T16B_SEQ_DUAL = 2'b11   // up then down, overflow at bottom
	} t16b_seq_t;
endpackage

// >>> src/t16b_io_if.sv
`timescale 1ns/1ns
`default_nettype none
interface t16b_io_if (
	input wire logic clk_i,
	input wire logic rst_i
);
	logic [3:0] io_addr;
	logic [7:0] io_wdata;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_rdata;
	logic       ovf_irq;

	modport cpu (
		input  clk_i, rst_i, io_rdata, ovf_irq,
		output io_addr, io_wdata, io_wr, io_rd
	);
	modport timer (
		input  clk_i, rst_i, io_addr, io_wdata, io_wr, io_rd,
		output io_rdata, ovf_irq
	);
endinterface
`default_nettype wire

// >>> src/t16b_timer.sv
// Operation
// - 16-bit values move as two byte accesses
// - one high-byte latch shared by all 16-bit registers
// - low-byte write loads latch and byte together
// - low-byte read copies high byte into latch
// - compare reads bypass the latch entirely
// - host writes high first, reads low first
// - host keeps two-byte accesses uninterrupted
// - latch holds value until next overwrite
// - tick from prescaler or external pin
// - 16-bit up/down counter with clear
// - top and bottom indications
// - counter high location accesses the latch
// - each tick clears, increments or decrements
// - select zero gives no ticks
// - counter accessible with or without ticks
// - CPU write beats clear or count
// - four-bit mode split over two controls
// - overflow flag set per mode, requests interrupt
// - host avoids writes in special cases
// - top is fixed, compare A or capture
// - maximum 0xFFFF, bottom 0x0000
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module t16b_timer
	import t16b_pkg::*;
(
	// Register side
	t16b_io_if.timer   bus,
	// Pins and status
	input  wire logic  ext_pin_i,
	output logic [15:0] count_o,
	output logic       top_o,
	output logic       bottom_o
);
	import t16b_pkg::*;

	logic [7:0]  ctrl_a;
	logic [7:0]  ctrl_b;
	logic [15:0] timer_count;
	logic [15:0] cmp_a;
	logic [15:0] cmp_b;
	logic [15:0] cap;
	logic [7:0]  hi_latch;
	logic        ovf_flag;
	logic        count_up;
	logic [9:0]  presc;
	logic [2:0]  pin_sync;
	logic        pin_level;
	logic        pin_level_q;
	logic        timer_tick;
	logic [2:0]  clock_source_select;
	logic [3:0]  waveform_mode_field;
	logic [15:0] top_val;
	t16b_seq_t   seq;
	logic        wr_cnt_lo;
	logic        ovf_set;
	logic [15:0] next_count;
	logic        next_up;

	// ------------------------------------------------------------
	// Mode decoding
	// ------------------------------------------------------------
	// Top value for a mode; modes 13 uses MAX as it is reserved
	function automatic logic [15:0] mode_top(input logic [3:0] m,
		input logic [15:0] ca, input logic [15:0] ic);
		case (m)
			4'h1, 4'h5: mode_top = TOP_8BIT;
			4'h2, 4'h6: mode_top = TOP_9BIT;
			4'h3, 4'h7: mode_top = TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: mode_top = ca;
			4'h8, 4'hA, 4'hC, 4'hE: mode_top = ic;
			default: mode_top = CNT_MAX;
		endcase
	endfunction

	function automatic t16b_seq_t mode_seq(input logic [3:0] m);
		case (m)
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB:
				mode_seq = T16B_SEQ_DUAL;
			4'h4, 4'hC: mode_seq = T16B_SEQ_CTC;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_seq = T16B_SEQ_FAST;
			default: mode_seq = T16B_SEQ_WRAP;
		endcase
	endfunction

	// Field split across both controls
	assign waveform_mode_field = {ctrl_b[WGM_HI_LSB +: 2],
		ctrl_a[WGM_LO_LSB +: 2]};
	assign clock_source_select = ctrl_b[CS_LSB +: 3];
	assign top_val = mode_top(waveform_mode_field, cmp_a, cap);
	assign seq     = mode_seq(waveform_mode_field);
	assign wr_cnt_lo = bus.io_wr && (bus.io_addr == LOC_CNT_LO);

	// ------------------------------------------------------------
	// Tick generation
	// ------------------------------------------------------------
	// Free-running prescaler; shared divider keeps phases aligned
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i)
			presc <= 10'h000;
		else
			presc <= presc + 10'h001;
	end

	// Three-stage pin sync; level moves only when stages 2 and 3 agree
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i) begin
			pin_sync    <= 3'h0;
			pin_level   <= 1'b0;
			pin_level_q <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], ext_pin_i};
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
			pin_level_q <= pin_level;
		end
	end

	// One-cycle tick enable from the selected source
	always_comb begin
		case (clock_source_select)
			CS_STOP:     timer_tick = 1'b0;
			CS_DIV1:     timer_tick = 1'b1;
			CS_DIV8:     timer_tick = &presc[2:0];
			CS_DIV64:    timer_tick = &presc[5:0];
			CS_DIV256:   timer_tick = &presc[7:0];
			CS_DIV1024:  timer_tick = &presc[9:0];
			CS_EXT_FALL: timer_tick = pin_level_q & ~pin_level;
			CS_EXT_RISE: timer_tick = ~pin_level_q & pin_level;
			default:     timer_tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Counter sequence
	// ------------------------------------------------------------
	// Next value on a tick, with its overflow event
	always_comb begin
		next_count = timer_count;
		next_up    = count_up;
		ovf_set    = 1'b0;
		case (seq)
			T16B_SEQ_WRAP: begin
				next_count = timer_count + 16'h0001;
				ovf_set = (timer_count == CNT_MAX);
			end
			T16B_SEQ_CTC: begin
				if (timer_count == top_val)
					next_count = CNT_BOTTOM;
				else
					next_count = timer_count + 16'h0001;
				ovf_set = (timer_count == CNT_MAX);
			end
			T16B_SEQ_FAST: begin
				if (timer_count >= top_val) begin
					next_count = CNT_BOTTOM;
					ovf_set = 1'b1;
				end else
					next_count = timer_count + 16'h0001;
			end
			T16B_SEQ_DUAL: begin
				// Turn at top and bottom; direction held between ticks
				if (count_up && timer_count >= top_val) begin
					next_up    = 1'b0;
					next_count = timer_count - 16'h0001;
				end else if (!count_up && timer_count == CNT_BOTTOM) begin
					next_up    = 1'b1;
					next_count = timer_count + 16'h0001;
					ovf_set    = 1'b1;
				end else if (count_up)
					next_count = timer_count + 16'h0001;
				else
					next_count = timer_count - 16'h0001;
			end
			default: next_count = timer_count;
		endcase
	end

	// Counter: a CPU write wins over any tick action
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i) begin
			timer_count <= VAL_RST;
			count_up    <= 1'b1;
		end else if (wr_cnt_lo) begin
			timer_count <= {hi_latch, bus.io_wdata};
		end else if (timer_tick) begin
			timer_count <= next_count;
			count_up    <= next_up;
		end
	end

	// Overflow flag: write one clears, a same-cycle set wins
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i)
			ovf_flag <= 1'b0;
		else if (timer_tick && ovf_set && !wr_cnt_lo)
			ovf_flag <= 1'b1;
		else if (bus.io_wr && bus.io_addr == LOC_FLAGS &&
			bus.io_wdata[OVF_BIT])
			ovf_flag <= 1'b0;
	end

	// ------------------------------------------------------------
	// Byte access
	// ------------------------------------------------------------
	// Control, compare and capture stores
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i) begin
			ctrl_a <= CTRL_RST;
			ctrl_b <= CTRL_RST;
			cmp_a  <= VAL_RST;
			cmp_b  <= VAL_RST;
			cap    <= VAL_RST;
		end else if (bus.io_wr) begin
			case (bus.io_addr)
				LOC_CTRL_A:  ctrl_a <= bus.io_wdata;
				LOC_CTRL_B:  ctrl_b <= bus.io_wdata;
				LOC_CMPA_LO: cmp_a <= {hi_latch, bus.io_wdata};
				LOC_CMPB_LO: cmp_b <= {hi_latch, bus.io_wdata};
				// Capture is writable only where it sets top
				LOC_CAP_LO:
					if (waveform_mode_field inside {4'h8, 4'hA, 4'hC, 4'hE})
						cap <= {hi_latch, bus.io_wdata};
				default: ;
			endcase
		end
	end

	// Shared latch: high writes fill it, counter and capture low reads copy into it
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i)
			hi_latch <= 8'h00;
		else if (bus.io_wr && (bus.io_addr == LOC_CNT_HI ||
			bus.io_addr == LOC_CMPA_HI || bus.io_addr == LOC_CMPB_HI ||
			bus.io_addr == LOC_CAP_HI))
			hi_latch <= bus.io_wdata;
		else if (bus.io_rd && bus.io_addr == LOC_CNT_LO)
			hi_latch <= timer_count[15:8];
		else if (bus.io_rd && bus.io_addr == LOC_CAP_LO)
			hi_latch <= cap[15:8];
	end

	// Read data, registered one cycle after the strobe
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i)
			bus.io_rdata <= 8'h00;
		else if (bus.io_rd) begin
			case (bus.io_addr)
				LOC_CTRL_A:  bus.io_rdata <= ctrl_a;
				LOC_CTRL_B:  bus.io_rdata <= ctrl_b;
				LOC_CNT_LO:  bus.io_rdata <= timer_count[7:0];
				LOC_CNT_HI:  bus.io_rdata <= hi_latch;
				LOC_CMPA_LO: bus.io_rdata <= cmp_a[7:0];
				LOC_CMPA_HI: bus.io_rdata <= cmp_a[15:8];
				LOC_CMPB_LO: bus.io_rdata <= cmp_b[7:0];
				LOC_CMPB_HI: bus.io_rdata <= cmp_b[15:8];
				LOC_CAP_LO:  bus.io_rdata <= cap[7:0];
				LOC_CAP_HI:  bus.io_rdata <= hi_latch;
				LOC_FLAGS:   bus.io_rdata <= {7'h00, ovf_flag};
				default:     bus.io_rdata <= 8'h00;
			endcase
		end
	end

	// Status outputs; top and bottom lag the counter by one cycle
	always_ff @(posedge bus.clk_i) begin
		if (bus.rst_i) begin
			count_o     <= VAL_RST;
			top_o       <= 1'b0;
			bottom_o    <= 1'b0;
			bus.ovf_irq <= 1'b0;
		end else begin
			count_o     <= timer_count;
			top_o       <= (timer_count == top_val);
			bottom_o    <= (timer_count == CNT_BOTTOM);
			bus.ovf_irq <= ovf_flag;
		end
	end
endmodule
`default_nettype wire

// >>> src/t16b_host.sv
`timescale 1ns/1ns
`default_nettype none
module t16b_host
	import t16b_pkg::*;
(
	// Wishbone slave
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Timer side
	t16b_io_if.cpu           io
);
	import t16b_pkg::*;

	typedef enum logic [2:0] {
		T16B_H_IDLE = 3'b000,
		T16B_H_STB1 = 3'b001,
		T16B_H_GET1 = 3'b010,
		T16B_H_STB2 = 3'b011,
		T16B_H_GET2 = 3'b100
	} t16b_hstate_t;

	t16b_hstate_t state;
	logic [3:0]   cmd_addr;
	logic         cmd_wr;
	logic         cmd_word;
	logic [15:0]  cmd_data;
	logic [15:0]  rd_data;
	logic         go;

	// Command accepted at the ack edge, only while idle
	assign go = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
		wb_adr_i == WB_CMD && wb_sel_i[0] && state == T16B_H_IDLE;

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	// One-cycle ack, dropped the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_adr_i == WB_STATUS)
				wb_dat_o <= {rd_data, 14'h0000, io.ovf_irq,
					state != T16B_H_IDLE};
			else if (wb_adr_i == WB_CMD)
				wb_dat_o <= {8'h00, cmd_data, 2'h0, cmd_word,
					cmd_wr, cmd_addr};
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_addr <= 4'h0;
			cmd_wr   <= 1'b0;
			cmd_word <= 1'b0;
			cmd_data <= 16'h0000;
		end else if (go) begin
			cmd_addr <= wb_dat_i[3:0];
			cmd_wr   <= wb_dat_i[CMD_WR_BIT];
			cmd_word <= wb_dat_i[CMD_WD_BIT];
			cmd_data <= wb_dat_i[CMD_DAT_LSB +: 16];
		end
	end

	// ------------------------------------------------------------
	// Byte sequencer
	// ------------------------------------------------------------
	// A word runs to completion before a new command, so no
	// second access can slip between its two halves
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state       <= T16B_H_IDLE;
			io.io_wr    <= 1'b0;
			io.io_rd    <= 1'b0;
			io.io_addr  <= 4'h0;
			io.io_wdata <= 8'h00;
			rd_data     <= 16'h0000;
		end else begin
			io.io_wr <= 1'b0;
			io.io_rd <= 1'b0;
			case (state)
				T16B_H_IDLE:
					if (go) begin
						state <= T16B_H_STB1;
						io.io_wr <= wb_dat_i[CMD_WR_BIT];
						io.io_rd <= !wb_dat_i[CMD_WR_BIT];
						// Word write: high location first
						if (wb_dat_i[CMD_WD_BIT] && wb_dat_i[CMD_WR_BIT]) begin
							io.io_addr  <= 4'(wb_dat_i[3:0] + 4'h1);
							io.io_wdata <= wb_dat_i[CMD_DAT_LSB + 8 +: 8];
						end else begin
							io.io_addr  <= wb_dat_i[3:0];  // Reads low first
							io.io_wdata <= wb_dat_i[CMD_DAT_LSB +: 8];
						end
					end
				T16B_H_STB1: state <= T16B_H_GET1;
				T16B_H_GET1: begin
					if (!cmd_wr)
						rd_data <= {8'h00, io.io_rdata};
					if (cmd_word) begin
						state    <= T16B_H_STB2;
						io.io_wr <= cmd_wr;
						io.io_rd <= !cmd_wr;
						io.io_addr <= cmd_wr ? cmd_addr : 4'(cmd_addr + 4'h1);
						io.io_wdata <= cmd_data[7:0];
					end else
						state <= T16B_H_IDLE;
				end
				T16B_H_STB2: state <= T16B_H_GET2;
				T16B_H_GET2: begin
					if (!cmd_wr)
						rd_data <= {io.io_rdata, rd_data[7:0]};
					state <= T16B_H_IDLE;
				end
				default: state <= T16B_H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> verification/t16b_io_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module t16b_io_assertions
	import t16b_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Byte link between the two ends
	input wire logic [3:0]  io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_rdata,
	input wire logic        ovf_irq,
	// Timer status outputs
	input wire logic [15:0] count_o,
	input wire logic        top_o,
	input wire logic        bottom_o
);
	logic [2:0] cs;
	logic [3:0] wgm;
	logic [7:0] hb;
	logic       hb_known;
	logic       stopped;
	logic       fixed;
	logic [15:0] ftop;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Shadow of select and mode, as written over the link
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs  <= CS_STOP;
			wgm <= 4'h0;
		end else if (io_wr && io_addr == LOC_CTRL_B) begin
			cs       <= io_wdata[2:0];
			wgm[3:2] <= io_wdata[4:3];
		end else if (io_wr && io_addr == LOC_CTRL_A) begin
			wgm[1:0] <= io_wdata[1:0];
		end
	end

	// Shadow latch; only trusted where its source is known
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hb       <= 8'h00;
			hb_known <= 1'b1;
		end else if (io_wr && io_addr[0] && io_addr >= LOC_CNT_HI
				&& io_addr <= LOC_CAP_HI) begin
			hb       <= io_wdata;
			hb_known <= 1'b1;
		end else if (io_rd && io_addr == LOC_CNT_LO) begin
			hb       <= count_o[15:8];
			hb_known <= stopped;
		end else if (io_rd && io_addr == LOC_CAP_LO) begin
			hb_known <= 1'b0;
		end
	end

	// Fixed top values of the fast and dual slope modes
	assign stopped = (cs == CS_STOP);
	assign fixed   = (wgm[2] || wgm[3:2] == 2'b00) && wgm[1:0] != 2'b00
		&& wgm[3] == 1'b0;
	assign ftop    = (wgm[1:0] == 2'b01) ? TOP_8BIT :
		(wgm[1:0] == 2'b10) ? TOP_9BIT : TOP_10BIT;

	a_strobe_single: assert property ((io_wr || io_rd) |=> !(io_wr || io_rd))
		else $error("link strobes not spaced");
	a_rdata_holds: assert property (!$past(io_rd) |-> $stable(io_rdata))
		else $error("read byte moved without a read");
	a_latch_readback: assert property (
		(io_rd && io_addr == LOC_CNT_HI && hb_known) |=> io_rdata == hb)
		else $error("high location did not return latch");
	a_low_write_join: assert property (
		(io_wr && io_addr == LOC_CNT_LO && hb_known) |=> ##1
		count_o == {$past(hb, 2), $past(io_wdata, 2)})
		else $error("low write did not load both bytes");
	a_low_read_copy: assert property (
		(io_rd && io_addr == LOC_CNT_LO && stopped) |=>
		io_rdata == count_o[7:0])
		else $error("low read returned wrong byte");
	a_stop_holds: assert property (
		($past(cs, 2) == CS_STOP && $past(cs, 3) == CS_STOP
		&& !$past(io_wr, 2)) |-> $stable(count_o))
		else $error("counter moved while stopped");
	a_div1_counts: assert property (
		($past(cs, 2) == CS_DIV1 && $past(cs, 3) == CS_DIV1
		&& $past(wgm, 2) == 4'h0 && $past(wgm, 3) == 4'h0
		&& !$past(io_wr, 2)) |-> count_o == $past(count_o) + 16'h0001)
		else $error("counter did not step by one");
	a_bottom_level: assert property (
		!$past(rst_i) |-> bottom_o == (count_o == CNT_BOTTOM))
		else $error("bottom indication wrong");
	a_top_fixed: assert property (
		(!$past(rst_i) && fixed && $stable(wgm) && $past(wgm, 2) == wgm)
		|-> top_o == (count_o == ftop))
		else $error("fixed top indication wrong");
	a_ovf_at_wrap: assert property (
		(cs == CS_DIV1 && wgm == 4'h0 && count_o == CNT_MAX ##1
		count_o == CNT_BOTTOM) |-> ##[0:4] ovf_irq)
		else $error("overflow flag not raised at wrap");
endmodule
`default_nettype wire

// >>> verification/t16b_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module t16b_tb_top
	import t16b_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [3:0]  wb_adr = 4'h0;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        ext_pin = 1'b0;
	logic [15:0] count;
	logic        top;
	logic        bottom;
	logic [31:0] q;
	logic [15:0] v, w, r, h, t;
	logic [3:0]  loc;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;

	always #4 clk_i = ~clk_i;

	t16b_io_if i_t16b_io_if (.clk_i(clk_i), .rst_i(rst_i));
	t16b_host i_t16b_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .io(i_t16b_io_if.cpu));
	t16b_timer i_t16b_timer (.bus(i_t16b_io_if.timer), .ext_pin_i(ext_pin),
		.count_o(count), .top_o(top), .bottom_o(bottom));
	t16b_io_assertions i_t16b_io_assertions (.clk_i(clk_i), .rst_i(rst_i),
		.io_addr(i_t16b_io_if.io_addr), .io_wdata(i_t16b_io_if.io_wdata),
		.io_wr(i_t16b_io_if.io_wr), .io_rd(i_t16b_io_if.io_rd),
		.io_rdata(i_t16b_io_if.io_rdata), .ovf_irq(i_t16b_io_if.ovf_irq),
		.count_o(count), .top_o(top), .bottom_o(bottom));

	// Verdict and end of run
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Hang guard, well above the longest expected run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			give_verdict();
		end
	end

	// Classic single Wishbone cycle; released after ack is seen or after 50 cycles without one
	task automatic wb(input logic we, input logic [3:0] a,
			input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		if (n >= 50) miscompares++;
	endtask

	// One link access through the command register, then poll for idle
	task automatic acc(input logic [3:0] l, input logic wr, input logic wd,
			input logic [15:0] d, output logic [15:0] res);
		logic [31:0] s;
		int n;
		wb(1'b1, WB_CMD, {8'h00, d, 2'b00, wd, wr, l}, s);
		n = 0;
		do begin
			wb(1'b0, WB_STATUS, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 20);
		if (n >= 20) miscompares++;
		res = s[31:16];
	endtask

	// Single compare for every 16-bit result
	task automatic chk(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	initial begin
		void'($urandom(71));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset state, latch read before any low read refills it
		acc(LOC_CNT_HI, 1'b0, 1'b0, 16'h0, r);
		chk("latch reset", 16'h0000, r);
		acc(LOC_CNT_LO, 1'b0, 1'b1, 16'h0, r);
		chk("count reset", VAL_RST, r);
		acc(LOC_FLAGS, 1'b0, 1'b0, 16'h0, r);
		chk("flags reset", 16'h0000, r);
		acc(LOC_CTRL_B, 1'b0, 1'b0, 16'h0, r);
		chk("select reset", {8'h00, CTRL_RST}, r);
		wb(1'b0, 4'h8, 32'h0, q);
		chk("unmapped lo", 16'h0000, q[15:0]);
		chk("unmapped hi", 16'h0000, q[31:16]);
		// Word round trips, extremes first, timer stopped
		for (int k = 0; k < 9; k++) begin
			v = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
			loc = (k % 3 == 0) ? LOC_CNT_LO :
				(k % 3 == 1) ? LOC_CMPA_LO : LOC_CMPB_LO;
			acc(loc, 1'b1, 1'b1, v, r);
			acc(loc, 1'b0, 1'b1, 16'h0, r);
			chk("word", v, r);
		end
		// One high write shared by two low writes
		h = 16'($urandom);
		v = 16'($urandom);
		w = 16'($urandom);
		acc(LOC_CNT_HI, 1'b1, 1'b0, {8'h00, h[7:0]}, r);
		acc(LOC_CMPA_LO, 1'b1, 1'b0, {8'h00, v[7:0]}, r);
		acc(LOC_CMPB_LO, 1'b1, 1'b0, {8'h00, w[7:0]}, r);
		acc(LOC_CMPA_LO, 1'b0, 1'b1, 16'h0, r);
		chk("cmpa shared", {h[7:0], v[7:0]}, r);
		acc(LOC_CMPB_LO, 1'b0, 1'b1, 16'h0, r);
		chk("cmpb shared", {h[7:0], w[7:0]}, r);
		// High location reaches the latch, never the counter
		v = 16'($urandom);
		acc(LOC_CNT_LO, 1'b1, 1'b1, v, r);
		acc(LOC_CNT_HI, 1'b1, 1'b0, {8'h00, ~v[15:8]}, r);
		acc(LOC_CNT_HI, 1'b0, 1'b0, 16'h0, r);
		chk("latch byte", {8'h00, ~v[15:8]}, r);
		acc(LOC_CNT_LO, 1'b0, 1'b1, 16'h0, r);
		chk("count kept", v, r);
		// Compare high read between the counter's two byte reads
		acc(LOC_CNT_LO, 1'b0, 1'b0, 16'h0, r);
		chk("count low", {8'h00, v[7:0]}, r);
		acc(LOC_CMPA_HI, 1'b0, 1'b0, 16'h0, r);
		chk("cmpa direct", {8'h00, h[7:0]}, r);
		acc(LOC_CNT_HI, 1'b0, 1'b0, 16'h0, r);
		chk("latch intact", {8'h00, v[15:8]}, r);
		repeat (30) @(posedge clk_i);
		acc(LOC_CNT_LO, 1'b0, 1'b1, 16'h0, r);
		chk("stopped", v, r);
		// Each nonzero select code; the pin gives five rising and five falling edges
		for (int c = 1; c < 8; c++) begin
			acc(LOC_CNT_LO, 1'b1, 1'b1, v, r);
			acc(LOC_CTRL_B, 1'b1, 1'b0, {13'h0, 3'(c)}, r);
			for (int e = 0; e < 5; e++) begin
				repeat (6) @(posedge clk_i);
				ext_pin <= 1'b1;
				repeat (6) @(posedge clk_i);
				ext_pin <= 1'b0;
			end
			if (c < 6) repeat (2100) @(posedge clk_i);
			repeat (8) @(posedge clk_i);
			acc(LOC_CTRL_B, 1'b1, 1'b0, 16'h0000, r);
			acc(LOC_CNT_LO, 1'b0, 1'b1, 16'h0, r);
			if (c == 7) chk("rise edges", v + 16'h0005, r);
			else if (c == 6) chk("fall edges", v + 16'h0005, r);
			else chk("moved", 16'h0001, {15'h0, r != v});
		end
		// Write while running, then overflow at wrap and its clearing
		acc(LOC_CTRL_B, 1'b1, 1'b0, {13'h0, CS_DIV1}, r);
		acc(LOC_CNT_LO, 1'b1, 1'b1, 16'hFFD0, r);
		repeat (80) @(posedge clk_i);
		acc(LOC_CTRL_B, 1'b1, 1'b0, 16'h0000, r);
		acc(LOC_FLAGS, 1'b0, 1'b0, 16'h0, r);
		chk("ovf set", 16'h0001, r & 16'h0001);
		wb(1'b0, WB_STATUS, 32'h0, q);
		chk("ovf status", 16'h0001, {15'h0, q[1]});
		acc(LOC_FLAGS, 1'b1, 1'b0, 16'h0001, r);
		acc(LOC_FLAGS, 1'b0, 1'b0, 16'h0, r);
		chk("ovf clear", 16'h0000, r & 16'h0001);
		// Fast modes wrap at their fixed tops
		for (int m = 5; m < 8; m++) begin
			t = (m == 5) ? TOP_8BIT : (m == 6) ? TOP_9BIT : TOP_10BIT;
			acc(LOC_CTRL_A, 1'b1, 1'b0, {14'h0, 2'(m)}, r);
			acc(LOC_CNT_LO, 1'b1, 1'b1, t - 16'h0010, r);
			acc(LOC_CTRL_B, 1'b1, 1'b0, {11'h0, 2'b01, CS_DIV1}, r);
			repeat (40) @(posedge clk_i);
			acc(LOC_CTRL_B, 1'b1, 1'b0, 16'h0000, r);
			acc(LOC_CNT_LO, 1'b0, 1'b1, 16'h0, r);
			chk("wrapped", 16'h0001, {15'h0, r < t - 16'h0010});
		end
		// Capture low write refused while capture does not set top
		acc(LOC_CAP_LO, 1'b1, 1'b1, 16'h1234, r);
		acc(LOC_CAP_LO, 1'b0, 1'b1, 16'h0, r);
		chk("cap refused", VAL_RST, r);
		// Dual slope with fixed top, then clear at capture top
		for (int m = 0; m < 2; m++) begin
			t = m ? 16'h0020 : TOP_8BIT;
			w = m ? 16'h0018 : 16'h0000;  // Mode bits [4:3]
			acc(LOC_CTRL_A, 1'b1, 1'b0, m ? 16'h0000 : 16'h0001, r);
			acc(LOC_CTRL_B, 1'b1, 1'b0, w, r);
			if (m) begin
				acc(LOC_CAP_LO, 1'b1, 1'b1, t, r);
				acc(LOC_CAP_LO, 1'b0, 1'b1, 16'h0, r);
				chk("cap top", t, r);
			end
			acc(LOC_CNT_LO, 1'b1, 1'b1, t - 16'h0010, r);
			acc(LOC_CTRL_B, 1'b1, 1'b0, w | 16'(CS_DIV1), r);
			repeat (40) @(posedge clk_i);
			acc(LOC_CTRL_B, 1'b1, 1'b0, 16'h0000, r);
			acc(LOC_CNT_LO, 1'b0, 1'b1, 16'h0, r);
			chk("under top", 16'h0001, {15'h0, r <= t});
		end
		give_verdict();
	end
endmodule
`default_nettype wire
